/* hdl/vcsp_serial_pins.sv */
// serial slave, reset, led and path bits of the voice chip pin interface
// Function
// - serial port active only while select low
// - capture mosi bit on sclk rising edge
// - change miso bit on sclk falling edge
// - miso released while select is high
// - reset low clears state and message pointers
// - led steady on throughout recording
// - led blinks during play, forward, erase
// - config bit routes auxiliary analog input
// - config bit enables microphone path
`timescale 1ns/1ps
module vcsp_serial_pins #(
  parameter int unsigned BLINK_HALF_CYC = vcsp_pkg::BLINK_HALF_CYC
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic resetPinN,
  input wire vcsp_pkg::vcsp_spi_pins_t spiPins,
  output logic misoOut,
  output logic misoOe,
  input wire vcsp_pkg::vcsp_byte_t txByte,
  output logic txTaken,
  output vcsp_pkg::vcsp_byte_t rxByte,
  output logic rxValid,
  output logic selected,
  input wire vcsp_pkg::vcsp_op_t opStatus,
  output logic ledOn,
  input wire logic [vcsp_pkg::CFG_W-1:0] cfgWord,
  input wire logic cfgLoad,
  output logic auxRoute,
  output logic micEnable,
  output logic pointerClear
);
  localparam vcsp_pkg::vcsp_blink_t BLINK_LAST =
    vcsp_pkg::vcsp_blink_t'(BLINK_HALF_CYC - 1);
  // ****************************************************************
  // pin synchronisers
  // ****************************************************************
  vcsp_pkg::vcsp_spi_pins_t pinS1_ff, pinS2_ff, pinS3_ff;
  logic rstS1_ff, rstS2_ff;
  logic intRst;
  // pins idle high after reset: select off, clock idle
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      pinS1_ff <= '1;
      pinS2_ff <= '1;
      pinS3_ff <= '1;
      rstS1_ff <= 1'b0;
      rstS2_ff <= 1'b0;
    end
    else
    begin
      pinS1_ff <= spiPins;
      pinS2_ff <= pinS1_ff;
      pinS3_ff <= pinS2_ff;
      rstS1_ff <= resetPinN;
      rstS2_ff <= rstS1_ff;
    end
  end
  // pin reset joins internal
  // no debounce: a bouncing pin simply re-resets
  assign intRst = reset | ~rstS2_ff;
  // ****************************************************************
  // serial slave
  // ****************************************************************
  logic sel, ssFall, sclkRise, sclkFall;
  vcsp_pkg::vcsp_bitcnt_t bitCnt_ff, nxt_bitCnt;
  vcsp_pkg::vcsp_byte_t rxShift_ff, nxt_rxShift, txShift_ff, nxt_txShift;
  vcsp_pkg::vcsp_byte_t rxByte_ff, nxt_rxByte;
  logic first_ff, nxt_first;
  logic rxValid_ff, nxt_rxValid, txTaken_ff, nxt_txTaken;
  logic misoOut_ff, nxt_misoOut, misoOe_ff, nxt_misoOe;
  logic selected_ff;
  assign sel = ~pinS2_ff.ssN;
  assign ssFall = ~pinS2_ff.ssN & pinS3_ff.ssN;
  assign sclkRise = pinS2_ff.sclk & ~pinS3_ff.sclk;
  assign sclkFall = ~pinS2_ff.sclk & pinS3_ff.sclk;
  always_comb
  begin
    nxt_bitCnt = bitCnt_ff;
    nxt_rxShift = rxShift_ff;
    nxt_txShift = txShift_ff;
    nxt_rxByte = rxByte_ff;
    nxt_first = first_ff;
    nxt_rxValid = 1'b0;
    nxt_txTaken = 1'b0;
    if (!sel)
    begin
      nxt_bitCnt = vcsp_pkg::BIT_FIRST;
      nxt_first = 1'b1;
    end
    else if (ssFall)
    begin
      nxt_txShift = txByte;
      nxt_txTaken = 1'b1;
      nxt_bitCnt = vcsp_pkg::BIT_FIRST;
      nxt_first = 1'b1;
    end
    else if (sclkRise)
    begin
      nxt_rxShift = {rxShift_ff[vcsp_pkg::FRAME_BITS-2:0], pinS2_ff.mosi};
      nxt_bitCnt = bitCnt_ff + 3'h1;
      nxt_first = 1'b0;
      if (bitCnt_ff == vcsp_pkg::BIT_LAST)
      begin
        nxt_rxByte = nxt_rxShift;
        nxt_rxValid = 1'b1;
      end
    end
    else if (sclkFall && !first_ff)
    begin
      // launch on falling edge
      // leading fall in mode three carries no shift
      if (bitCnt_ff == vcsp_pkg::BIT_FIRST)
      begin
        nxt_txShift = txByte;
        nxt_txTaken = 1'b1;
      end
      else
      begin
        nxt_txShift = {txShift_ff[vcsp_pkg::FRAME_BITS-2:0], 1'b0};
      end
    end
    nxt_misoOut = nxt_txShift[vcsp_pkg::FRAME_BITS-1];
    nxt_misoOe = ~sel;
  end
  always_ff @(posedge clk)
  begin
    if (intRst)
    begin
      bitCnt_ff <= vcsp_pkg::BIT_FIRST;
      rxShift_ff <= vcsp_pkg::BYTE_RESET;
      txShift_ff <= vcsp_pkg::BYTE_RESET;
      rxByte_ff <= vcsp_pkg::BYTE_RESET;
      first_ff <= 1'b1;
      rxValid_ff <= 1'b0;
      txTaken_ff <= 1'b0;
      misoOut_ff <= 1'b0;
      misoOe_ff <= 1'b1;
      selected_ff <= 1'b0;
    end
    else
    begin
      bitCnt_ff <= nxt_bitCnt;
      rxShift_ff <= nxt_rxShift;
      txShift_ff <= nxt_txShift;
      rxByte_ff <= nxt_rxByte;
      first_ff <= nxt_first;
      rxValid_ff <= nxt_rxValid;
      txTaken_ff <= nxt_txTaken;
      misoOut_ff <= nxt_misoOut;
      misoOe_ff <= nxt_misoOe;
      selected_ff <= sel;
    end
  end
  // ****************************************************************
  // led and path configuration
  // ****************************************************************
  vcsp_pkg::vcsp_blink_t blinkCnt_ff, nxt_blinkCnt;
  logic ledOn_ff, nxt_ledOn, blinkAct;
  logic auxRoute_ff, nxt_auxRoute, micEnable_ff, nxt_micEnable;
  logic pointerClear_ff;
  assign blinkAct = opStatus.playing | opStatus.forwarding | opStatus.erasing;
  always_comb
  begin
    nxt_blinkCnt = '0;
    nxt_ledOn = 1'b0;
    if (opStatus.recording)
    begin
      nxt_ledOn = 1'b1;
    end
    else if (blinkAct)
    begin
      if (blinkCnt_ff >= BLINK_LAST)
      begin
        nxt_ledOn = ~ledOn_ff;
      end
      else
      begin
        nxt_blinkCnt = blinkCnt_ff + 1'b1;
        nxt_ledOn = ledOn_ff;
      end
    end
    nxt_auxRoute = auxRoute_ff;
    nxt_micEnable = micEnable_ff;
    if (cfgLoad)
    begin
      nxt_auxRoute = cfgWord[vcsp_pkg::CFG_AUX_BIT];
      nxt_micEnable = cfgWord[vcsp_pkg::CFG_MIC_BIT];
    end
  end
  always_ff @(posedge clk)
  begin
    if (intRst)
    begin
      blinkCnt_ff <= '0;
      ledOn_ff <= 1'b0;
      auxRoute_ff <= vcsp_pkg::CFG_AUX_RESET;
      micEnable_ff <= vcsp_pkg::CFG_MIC_RESET;
      pointerClear_ff <= 1'b1;
    end
    else
    begin
      blinkCnt_ff <= nxt_blinkCnt;
      ledOn_ff <= nxt_ledOn;
      auxRoute_ff <= nxt_auxRoute;
      micEnable_ff <= nxt_micEnable;
      pointerClear_ff <= 1'b0;
    end
  end
  assign misoOut = misoOut_ff;
  assign misoOe = misoOe_ff;
  assign txTaken = txTaken_ff;
  assign rxByte = rxByte_ff;
  assign rxValid = rxValid_ff;
  assign selected = selected_ff;
  assign ledOn = ledOn_ff;
  assign auxRoute = auxRoute_ff;
  assign micEnable = micEnable_ff;
  assign pointerClear = pointerClear_ff;
  // ****************************************************************
  // checks
  // ****************************************************************
  property p_rxOnlySel;
    @(posedge clk) disable iff (intRst) rxValid_ff |-> $past(sel);
  endproperty
  a_rxOnlySel: assert property (p_rxOnlySel)
    else $error("byte completed while not selected");
  property p_rxCapture;
    @(posedge clk) disable iff (intRst)
      (sel && !ssFall && sclkRise && bitCnt_ff == vcsp_pkg::BIT_LAST) |=>
      (rxValid_ff && rxByte_ff ==
        {$past(rxShift_ff[vcsp_pkg::FRAME_BITS-2:0]), $past(pinS2_ff.mosi)});
  endproperty
  a_rxCapture: assert property (p_rxCapture)
    else $error("received byte wrong after last rise");
  property p_misoOnFall;
    @(posedge clk) disable iff (intRst)
      $changed(misoOut_ff) |-> $past(sclkFall || ssFall, 1);
  endproperty
  a_misoOnFall: assert property (p_misoOnFall)
    else $error("miso changed without falling edge");
  property p_misoRelease;
    @(posedge clk) disable iff (intRst) !sel |=> misoOe_ff;
  endproperty
  a_misoRelease: assert property (p_misoRelease)
    else $error("miso driven while deselected");
  property p_resetClears;
    @(posedge clk) reset |=>
      (pointerClear_ff && !ledOn_ff && bitCnt_ff == vcsp_pkg::BIT_FIRST);
  endproperty
  a_resetClears: assert property (p_resetClears)
    else $error("state not cleared by reset");
  property p_ledRecord;
    @(posedge clk) disable iff (intRst) opStatus.recording |=> ledOn_ff;
  endproperty
  a_ledRecord: assert property (p_ledRecord)
    else $error("led off during recording");
  property p_ledBlink;
    @(posedge clk) disable iff (intRst)
      (!opStatus.recording && blinkAct && blinkCnt_ff == BLINK_LAST) |=>
      (ledOn_ff != $past(ledOn_ff));
  endproperty
  a_ledBlink: assert property (p_ledBlink)
    else $error("led did not toggle at half period");
  property p_auxLoad;
    @(posedge clk) disable iff (intRst)
      cfgLoad |=> auxRoute_ff == $past(cfgWord[vcsp_pkg::CFG_AUX_BIT]);
  endproperty
  a_auxLoad: assert property (p_auxLoad)
    else $error("aux routing bit not loaded");
  property p_micLoad;
    @(posedge clk) disable iff (intRst)
      cfgLoad |=> micEnable_ff == $past(cfgWord[vcsp_pkg::CFG_MIC_BIT]);
  endproperty
  a_micLoad: assert property (p_micLoad)
    else $error("mic enable bit not loaded");
  property p_blinkBound;
    @(posedge clk) disable iff (intRst) blinkCnt_ff <= BLINK_LAST;
  endproperty
  a_blinkBound: assert property (p_blinkBound)
    else $error("blink counter past its period");
endmodule : vcsp_serial_pins

/* hdl/vcsp_pkg.sv */
// constants and carrier types for the voice chip serial pin block
package vcsp_pkg;

  // ****************************************************************
  // serial frame
  // ****************************************************************
  localparam int unsigned FRAME_BITS = 8;
  localparam int unsigned BIT_CNT_W = 3;
  localparam logic [BIT_CNT_W-1:0] BIT_FIRST = 3'h0;
  localparam logic [BIT_CNT_W-1:0] BIT_LAST = 3'h7;
  localparam logic [FRAME_BITS-1:0] BYTE_RESET = 8'h00;

  // ****************************************************************
  // analog path configuration word
  // ****************************************************************
  localparam int unsigned CFG_W = 12;
  localparam int unsigned CFG_AUX_BIT = 3;
  localparam int unsigned CFG_MIC_BIT = 4;
  localparam logic CFG_AUX_RESET = 1'b0;
  localparam logic CFG_MIC_RESET = 1'b0;

  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int unsigned CLK_MHZ = 200;
  localparam int unsigned BLINK_HALF_MS = 250;
  localparam int unsigned BLINK_HALF_CYC = BLINK_HALF_MS * CLK_MHZ * 1000;
  localparam int unsigned BLINK_CNT_W = 26;

  typedef logic [BLINK_CNT_W-1:0] vcsp_blink_t;
  typedef logic [BIT_CNT_W-1:0] vcsp_bitcnt_t;
  typedef logic [FRAME_BITS-1:0] vcsp_byte_t;

  // ****************************************************************
  // carriers
  // ****************************************************************
  typedef struct packed {
    logic ssN;
    logic sclk;
    logic mosi;
  } vcsp_spi_pins_t;

  typedef struct packed {
    logic recording;
    logic playing;
    logic forwarding;
    logic erasing;
  } vcsp_op_t;

endpackage : vcsp_pkg

/* dv/vcsp_host_model.sv */
// host serial master model driving the voice chip pin block
`timescale 1ns/1ps
module vcsp_host_model (
  output vcsp_pkg::vcsp_spi_pins_t spiPins,
  input wire logic misoOut,
  input wire logic misoOe,
  output logic misoWire
);
  logic lastMiso = 1'b0;
  // ****************************************************************
  // miso wire level
  // ****************************************************************
  // no pull-up on miso: a released line shows the inverse of last level
  assign misoWire = misoOe ? ~lastMiso : misoOut;
  always @(misoOut or misoOe)
    if (!misoOe)
      lastMiso = misoOut;
  initial
  begin
    spiPins = '{ssN: 1'b1, sclk: 1'b1, mosi: 1'b1};
  end
  // ****************************************************************
  // bus tasks
  // ****************************************************************
  task automatic sel(input logic on);
    spiPins.ssN = ~on;
    // mosi pull-up takes over once released
    if (!on)
      spiPins.mosi = 1'b1;
    #62.5;
  endtask : sel
  task automatic xbits(input vcsp_pkg::vcsp_byte_t mo, input int n,
                       output vcsp_pkg::vcsp_byte_t mi);
    mi = 8'h00;
    for (int i = 7; i > 7 - n; i--)
    begin
      spiPins.sclk = 1'b0;
      spiPins.mosi = mo[i];
      #62.5;
      spiPins.sclk = 1'b1;
      mi[i] = misoWire;
      #62.5;
    end
  endtask : xbits
endmodule : vcsp_host_model

/* dv/tb_vcsp_serial_pins.sv */
// self-checking bench for the voice chip serial pin block
`timescale 1ns/1ps
module tb_vcsp_serial_pins;
  localparam int unsigned HALF = 8;
  logic clk, reset, resetPinN, misoOut, misoOe, misoWire, txTaken;
  logic rxValid, selected, ledOn, cfgLoad, auxRoute, micEnable;
  logic pointerClear;
  logic [vcsp_pkg::CFG_W-1:0] cfgWord;
  vcsp_pkg::vcsp_spi_pins_t spiPins;
  vcsp_pkg::vcsp_byte_t txByte, rxByte, scratch;
  vcsp_pkg::vcsp_op_t opStatus;
  vcsp_pkg::vcsp_byte_t rxExp[$];
  vcsp_pkg::vcsp_byte_t txSent[$];
  int failures, cmpCount;
  vcsp_serial_pins #(.BLINK_HALF_CYC(HALF)) dut (.clk(clk), .reset(reset),
    .resetPinN(resetPinN), .spiPins(spiPins), .misoOut(misoOut),
    .misoOe(misoOe), .txByte(txByte), .txTaken(txTaken), .rxByte(rxByte),
    .rxValid(rxValid), .selected(selected), .opStatus(opStatus),
    .ledOn(ledOn), .cfgWord(cfgWord), .cfgLoad(cfgLoad),
    .auxRoute(auxRoute), .micEnable(micEnable), .pointerClear(pointerClear));
  vcsp_host_model host (.spiPins(spiPins), .misoOut(misoOut),
    .misoOe(misoOe), .misoWire(misoWire));
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // ****************************************************************
  // helpers
  // ****************************************************************
  task automatic check(input string what, input logic [11:0] exp,
                       input logic [11:0] got);
    cmpCount++;
    if (got !== exp)
    begin
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      failures++;
    end
  endtask : check
  task automatic give_verdict();
    $display("counts: %0d compares, %0d failures", cmpCount, failures);
    if (failures == 0 && cmpCount > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : give_verdict
  task automatic frame(input int nbytes, input int lastBits);
    vcsp_pkg::vcsp_byte_t mo, mi;
    int n;
    txSent.delete();
    #1 host.sel(1'b1);
    for (int b = 0; b < nbytes; b++)
    begin
      mo = vcsp_pkg::vcsp_byte_t'($urandom);
      n = (b == nbytes - 1) ? lastBits : 8;
      if (n == 8)
        rxExp.push_back(mo);
      host.xbits(mo, n, mi);
      if (n == 8)
        check("miso byte", {4'h0, txSent.pop_front()}, {4'h0, mi});
      check("selected", 12'h001, {11'h000, selected});
    end
    host.sel(1'b0);
    repeat (8) @(posedge clk);
    check("miso released", 12'h001, {11'h000, misoOe});
    check("deselected", 12'h000, {11'h000, selected});
  endtask : frame
  task automatic blink(input vcsp_pkg::vcsp_op_t op);
    int gap, seen;
    logic prev;
    gap = 0;
    seen = 0;
    prev = ledOn;
    opStatus = op;
    for (int t = 0; t < 100 && seen < 3; t++)
    begin
      @(posedge clk);
      #1 gap++;
      if (ledOn !== prev)
      begin
        if (seen > 0)
          check("blink half", 12'(HALF), 12'(gap));
        seen++;
        gap = 0;
        prev = ledOn;
      end
    end
    check("blink seen", 12'h003, 12'(seen));
  endtask : blink
  // ****************************************************************
  // watchers
  // ****************************************************************
  always @(posedge clk)
    if (txTaken === 1'b1)
    begin
      txSent.push_back(txByte);
      #1 txByte = vcsp_pkg::vcsp_byte_t'($urandom);
    end
  always @(posedge clk)
    if (rxValid === 1'b1)
    begin
      if (rxExp.size() == 0)
        check("unexpected rx", 12'h000, 12'h001);
      else
        check("rx byte", {4'h0, rxExp.pop_front()}, {4'h0, rxByte});
    end
  initial
  begin
    #400000 failures++;
    $display("CHECK FAILED watchdog expected end seen hang");
    give_verdict();
  end
  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial
  begin
    failures = 0;
    cmpCount = 0;
    void'($urandom(32'hE9DA));
    reset = 1'b1;
    resetPinN = 1'b1;
    txByte = vcsp_pkg::vcsp_byte_t'($urandom);
    opStatus = '0;
    cfgWord = 12'h000;
    cfgLoad = 1'b0;
    repeat (16) @(posedge clk);
    check("clear in reset", 12'h001, {11'h000, pointerClear});
    check("oe in reset", 12'h001, {11'h000, misoOe});
    #1 reset = 1'b0;
    repeat (6) @(posedge clk);
    check("clear after", 12'h000, {11'h000, pointerClear});
    $display("test reset done");
    frame(2, 8);
    frame(1, 5);
    #1 host.xbits(8'hA5, 8, scratch);
    repeat (8) @(posedge clk);
    check("oe idle", 12'h001, {11'h000, misoOe});
    check("rx pending", 12'h000, 12'(rxExp.size()));
    $display("test serial done");
    for (int k = 0; k < 4; k++)
    begin
      @(posedge clk);
      #1 cfgWord = 12'($urandom);
      cfgWord[vcsp_pkg::CFG_AUX_BIT] = k[0];
      cfgWord[vcsp_pkg::CFG_MIC_BIT] = k[1];
      cfgLoad = 1'b1;
      @(posedge clk);
      #1 cfgLoad = 1'b0;
      cfgWord = ~cfgWord;
      check("aux route", {11'h000, k[0]}, {11'h000, auxRoute});
      check("mic enable", {11'h000, k[1]}, {11'h000, micEnable});
    end
    repeat (2) @(posedge clk);
    check("config held", 12'h003, {10'h000, micEnable, auxRoute});
    $display("test config done");
    #1 resetPinN = 1'b0;
    for (int t = 0; t < 10 && pointerClear !== 1'b1; t++)
      @(posedge clk);
    #1 check("pin clear", 12'h001, {11'h000, pointerClear});
    check("pin config", 12'h000, {10'h000, micEnable, auxRoute});
    resetPinN = 1'b1;
    for (int t = 0; t < 10 && pointerClear !== 1'b0; t++)
      @(posedge clk);
    #1 check("pin release", 12'h000, {11'h000, pointerClear});
    $display("test reset pin done");
    opStatus = '{recording: 1'b1, playing: 1'b1, forwarding: 1'b0,
                 erasing: 1'b0};
    repeat (2) @(posedge clk);
    for (int t = 0; t < 3 * HALF; t++)
    begin
      @(posedge clk);
      #1 check("led record", 12'h001, {11'h000, ledOn});
    end
    blink(4'b0100);
    blink(4'b0010);
    blink(4'b0001);
    opStatus = '0;
    repeat (3) @(posedge clk);
    check("led off", 12'h000, {11'h000, ledOn});
    $display("test led done");
    give_verdict();
  end
endmodule : tb_vcsp_serial_pins
